// [logic/nvsq_host.sv]
// Host controller driving a store/recall SRAM through its pins
//
// Operation
// R1: Device floats data when write strobe is low as select falls.
// R2: Host keeps store-busy high during every write cycle.
// R3: Host keeps select or write high while the address changes.
// R4: Device finishes power-up restore within 550 us.
// R5: Store cycle finishes within 10 ms.
// R6: Host ends any running cycle within the 1 us grace time.
// R7: Device drives store-busy low 1 us on backup supply fall.
// R8: Device skips automatic store when nothing was written.
// R9: Device pulls store-busy low within 300 ns of trigger.
// R10: Host holds store-busy low at least 15 ns to request.
// R11: Device drives store-busy low within 300 ns of request.
// R12: Device accepts cycles within 700 ns after store-busy rises.
// R13: Request stores only after a write; device inhibited until rise.
// R14: Device abandons power-fail store if line stays high.
// R15: Device starts nonvolatile cycles whatever output enable is.
// R16: Host keeps write strobe and store-busy high during reads.
// R17: Device write-pending flag decides whether a store proceeds.
`timescale 1ns/100ps
`default_nettype none
module nvsq_host #(
  parameter int ADDR_W = 11,
  parameter int DATA_W = 8,
  parameter int RESTORE_CYC = nvsq_pkg::RESTORE_CYC,
  parameter int SHADOW_COPY_CYC = nvsq_pkg::SHADOW_COPY_CYC
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // User request side
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  input wire logic store_req_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [DATA_W-1:0] rsp_rdata_out,
  output logic store_done_out,
  output logic busy_out,
  // Memory pins
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic mem_sel_n_out,
  output logic mem_wr_n_out,
  output logic mem_oe_n_out,
  input wire logic [DATA_W-1:0] mem_dq_in,
  output logic [DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe_out,
  // Store-busy line, open drain
  input wire logic store_busy_line_in,
  output logic store_busy_line_out,
  output logic store_busy_line_oe_out
);
  localparam int CNT_W = $clog2(SHADOW_COPY_CYC + RESTORE_CYC + 2) + 1;
  // Access phases: setup, strobe, release
  localparam logic [1:0] PH_LAST = 2'h2;

  // R6: access fits grace time
  if (ADDR_W < 1 || DATA_W < 1 || RESTORE_CYC < 1 || SHADOW_COPY_CYC < 1 ||
      int'(PH_LAST) + 1 > nvsq_pkg::GRACE_CYC) begin : g_bad_param
    $error("nvsq_host: bad parameter");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  logic rst_n;
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  nvsq_pkg::nvsq_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic wr_q, wr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic rsp_q, rsp_d;
  logic done_q, done_d;
  logic pend_q, pend_d;
  logic sel_n_q, sel_n_d;
  logic wr_n_q, wr_n_d;
  logic oe_n_q, oe_n_d;
  logic dq_oe_q, dq_oe_d;
  logic drive_q, drive_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ph_d = ph_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rsp_d = 1'b0;
    done_d = 1'b0;
    pend_d = pend_q;
    sel_n_d = 1'b1;
    wr_n_d = 1'b1;
    oe_n_d = 1'b1;
    dq_oe_d = 1'b0;
    drive_d = 1'b0;
    unique case (state_q)
      // R4: wait out restore
      nvsq_pkg::NVSQ_BOOT: begin
        if (cnt_q == CNT_W'(RESTORE_CYC)) begin
          state_d = nvsq_pkg::NVSQ_IDLE;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      nvsq_pkg::NVSQ_IDLE: begin
        cnt_d = '0;
        // Device-side busy (power-fail store) blocks new cycles
        if (!store_busy_line_in) begin
          state_d = nvsq_pkg::NVSQ_WAIT;
        end else if (store_req_in) begin
          // R13: skip when nothing written
          if (pend_q) begin
            state_d = nvsq_pkg::NVSQ_REQ;
            drive_d = 1'b1;
          end else begin
            done_d = 1'b1;
          end
        end else if (req_valid_in) begin
          // R3: address set while strobes high
          state_d = nvsq_pkg::NVSQ_ACC;
          ph_d = 2'h0;
          wr_d = req_write_in;
          addr_d = req_addr_in;
          wdata_d = req_wdata_in;
        end
      end
      nvsq_pkg::NVSQ_ACC: begin
        ph_d = ph_q + 1'b1;
        // R2: line released during write; R16: write high on read
        if (ph_q != PH_LAST) begin
          sel_n_d = 1'b0;
          wr_n_d = !wr_q;
          oe_n_d = wr_q;
          dq_oe_d = wr_q;
        end else begin
          // Data sampled at the end of the strobe phase
          state_d = nvsq_pkg::NVSQ_IDLE;
          rsp_d = 1'b1;
          if (!wr_q) begin
            rdata_d = mem_dq_in;
          end else begin
            // R17: mirror device write-pending
            pend_d = 1'b1;
          end
        end
      end
      // R10: hold request low long enough
      nvsq_pkg::NVSQ_REQ: begin
        drive_d = 1'b1;
        cnt_d = cnt_q + 1'b1;
        // Hold covers both pulse width and device takeover time
        if (cnt_q + 1'b1 >= CNT_W'(nvsq_pkg::REQ_PULSE_CYC + nvsq_pkg::REQ_BUSY_CYC)) begin
          drive_d = 1'b0;
          state_d = nvsq_pkg::NVSQ_WAIT;
          cnt_d = '0;
        end
      end
      // R5: store bounded, then release wait
      nvsq_pkg::NVSQ_WAIT: begin
        cnt_d = cnt_q + 1'b1;
        if (store_busy_line_in && cnt_q >= CNT_W'(nvsq_pkg::GRACE_CYC)) begin
          state_d = nvsq_pkg::NVSQ_REL;
          cnt_d = '0;
        end else if (cnt_q == CNT_W'(SHADOW_COPY_CYC)) begin
          // Line stuck low: give up waiting rather than hang
          state_d = nvsq_pkg::NVSQ_REL;
          cnt_d = '0;
        end
      end
      // R12: inhibit release time
      nvsq_pkg::NVSQ_REL: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q + 1'b1 >= CNT_W'(nvsq_pkg::INHIBIT_REL_CYC)) begin
          state_d = nvsq_pkg::NVSQ_IDLE;
          pend_d = 1'b0;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = nvsq_pkg::NVSQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= nvsq_pkg::NVSQ_BOOT;
      cnt_q <= '0;
      ph_q <= 2'h0;
      wr_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      rsp_q <= 1'b0;
      done_q <= 1'b0;
      pend_q <= 1'b0;
      sel_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      dq_oe_q <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rsp_q <= rsp_d;
      done_q <= done_d;
      pend_q <= pend_d;
      sel_n_q <= sel_n_d;
      wr_n_q <= wr_n_d;
      oe_n_q <= oe_n_d;
      dq_oe_q <= dq_oe_d;
      drive_q <= drive_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready_out = (state_q == nvsq_pkg::NVSQ_IDLE) && store_busy_line_in && !store_req_in;
  assign rsp_valid_out = rsp_q;
  assign rsp_rdata_out = rdata_q;
  assign store_done_out = done_q;
  assign busy_out = (state_q != nvsq_pkg::NVSQ_IDLE);
  assign mem_addr_out = addr_q;
  assign mem_sel_n_out = sel_n_q;
  assign mem_wr_n_out = wr_n_q;
  assign mem_oe_n_out = oe_n_q;
  assign mem_dq_out = wdata_q;
  assign mem_dq_oe_out = dq_oe_q;
  assign store_busy_line_out = 1'b0;
  assign store_busy_line_oe_out = drive_q;
endmodule // nvsq_host
`default_nettype wire

// [logic/nvsq_pkg.sv]
// Package of constants for the nonvolatile store/recall host controller
`default_nettype none
package nvsq_pkg;
  // Clock rate in kHz (10 MHz)
  localparam int CLK_KHZ = 10000;
  // Printed times, in their own units
  localparam int RESTORE_US = 550;
  localparam int SHADOW_COPY_MS = 10;
  localparam int GRACE_US = 1;
  localparam int TRIG_BUSY_NS = 300;
  localparam int REQ_PULSE_NS = 15;
  localparam int REQ_BUSY_NS = 300;
  localparam int INHIBIT_REL_NS = 700;
  // Derived cycle counts: least times and grace round up, other longest round down; the ns-based counts never below one
  localparam int RESTORE_CYC = RESTORE_US * CLK_KHZ / 1000;
  localparam int SHADOW_COPY_CYC = SHADOW_COPY_MS * CLK_KHZ;
  localparam int GRACE_CYC = (GRACE_US * CLK_KHZ + 999) / 1000;
  localparam int REQ_PULSE_CYC_RAW = (REQ_PULSE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int REQ_PULSE_CYC = (REQ_PULSE_CYC_RAW < 1) ? 1 : REQ_PULSE_CYC_RAW;
  localparam int REQ_BUSY_CYC_RAW = REQ_BUSY_NS * CLK_KHZ / 1000000;
  localparam int REQ_BUSY_CYC = (REQ_BUSY_CYC_RAW < 1) ? 1 : REQ_BUSY_CYC_RAW;
  localparam int INHIBIT_REL_CYC_RAW = INHIBIT_REL_NS * CLK_KHZ / 1000000;
  localparam int INHIBIT_REL_CYC = (INHIBIT_REL_CYC_RAW < 1) ? 1 : INHIBIT_REL_CYC_RAW;
  localparam int TRIG_BUSY_CYC_RAW = TRIG_BUSY_NS * CLK_KHZ / 1000000;
  localparam int TRIG_BUSY_CYC = (TRIG_BUSY_CYC_RAW < 1) ? 1 : TRIG_BUSY_CYC_RAW;
  // Controller states, one-hot
  typedef enum logic [5:0] {
    NVSQ_BOOT = 6'h01,
    NVSQ_IDLE = 6'h02,
    NVSQ_ACC = 6'h04,
    NVSQ_REQ = 6'h08,
    NVSQ_WAIT = 6'h10,
    NVSQ_REL = 6'h20
  } nvsq_state_t;
endpackage
`default_nettype wire

// [verif/nvsq_host_checker.sv]
// Pin-level property checker for the store/recall host controller
`timescale 1ns/100ps
`default_nettype none
module nvsq_host_checker (
  // Watched ports
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic [10:0] mem_addr_out,
  input wire logic mem_sel_n_out,
  input wire logic mem_wr_n_out,
  input wire logic mem_oe_n_out,
  input wire logic mem_dq_oe_out,
  input wire logic rsp_valid_out,
  input wire logic store_done_out,
  input wire logic store_busy_line_in,
  input wire logic store_busy_line_oe_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  chk_write_no_pull: assert property (!mem_wr_n_out |-> !store_busy_line_oe_out)
    else $error("store line pulled during write");
  chk_addr_steady: assert property ($changed(mem_addr_out) |-> $past(mem_sel_n_out) || $past(mem_wr_n_out))
    else $error("address moved inside write");
  chk_read_quiet: assert property (!mem_oe_n_out |-> mem_wr_n_out && !store_busy_line_oe_out)
    else $error("read not quiet");
  chk_req_pulse: assert property ($rose(store_busy_line_oe_out) |-> store_busy_line_oe_out[*4] ##1 !store_busy_line_oe_out)
    else $error("store request pulse length wrong");
  chk_grace_end: assert property (!store_busy_line_in |-> ##[0:2] mem_sel_n_out)
    else $error("cycle not ended within grace");
  chk_dq_drive: assert property (mem_dq_oe_out == !mem_wr_n_out)
    else $error("data drive not tied to write strobe");
  chk_access_shape: assert property ($fell(mem_sel_n_out) |=> !mem_sel_n_out ##1 (mem_sel_n_out && rsp_valid_out))
    else $error("access shape wrong");
  chk_done_line_high: assert property (store_done_out |-> store_busy_line_in && $past(store_busy_line_in))
    else $error("store done while line low");
  cover property (!mem_wr_n_out);
  cover property (!mem_oe_n_out);
  cover property ($rose(store_busy_line_oe_out));
endmodule // nvsq_host_checker
bind nvsq_host nvsq_host_checker chk_u (.mclk_in, .arst_n_in, .mem_addr_out, .mem_sel_n_out, .mem_wr_n_out,
  .mem_oe_n_out, .mem_dq_oe_out, .rsp_valid_out, .store_done_out, .store_busy_line_in, .store_busy_line_oe_out);
`default_nettype wire

// [verif/nvsq_dev_model.sv]
// Behavioural store/recall SRAM answering the host pins
`timescale 1ns/100ps
`default_nettype none
module nvsq_dev_model #(parameter int COPY_CYC = 30) (
  // Pins from the host, plus the supply-fail input
  input wire logic clk_in,
  input wire logic [10:0] addr_in,
  input wire logic sel_n_in,
  input wire logic wr_n_in,
  input wire logic oe_n_in,
  input wire logic [7:0] dq_in,
  input wire logic line_in,
  input wire logic pfail_in,
  // Answers
  output logic [7:0] dq_out,
  output logic pull_out
);
  logic [7:0] mem [2048];
  logic [7:0] rd_q = 8'h00;
  logic [1:0] vld_q = 2'h0;
  logic float_q = 1'b0;
  logic sel_n_q = 1'b1;
  int cnt_q = 0;
  // restore done at start, nothing pending
  logic pend_q = 1'b0;
  // Released bus shows inverted data, never the old value
  assign dq_out = (vld_q != 2'h0) ? rd_q : ~rd_q;
  assign pull_out = cnt_q > 0;
  // Float decision must apply in the very cycle select falls
  logic float_now;
  assign float_now = sel_n_q ? !wr_n_in : float_q;
  always @(posedge clk_in) begin
    sel_n_q <= sel_n_in;
    // write low at select fall keeps outputs off
    if (sel_n_q && !sel_n_in)
      float_q <= !wr_n_in;
    // writes accepted only while the model is not pulling the line, mark pending
    if (!sel_n_in && !wr_n_in && cnt_q == 0) begin
      mem[addr_in] <= dq_in;
      pend_q <= 1'b1;
    end
    if (!sel_n_in && wr_n_in && !oe_n_in && !float_now && cnt_q == 0) begin
      rd_q <= mem[addr_in];
      vld_q <= 2'h2;
    end else if (vld_q != 2'h0)
      vld_q <= vld_q - 2'h1;
    if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
      // copy ends well inside its limit
      if (cnt_q == 1)
        pend_q <= 1'b0;
    end
    // supply drop pulls at once, copies only when pending
    else if (pfail_in)
      cnt_q <= pend_q ? COPY_CYC : 10;
    // external low copies only when pending
    else if (!line_in && pend_q)
      cnt_q <= COPY_CYC;
  end
endmodule // nvsq_dev_model
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the store/recall host controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic valid = 1'b0, wr = 1'b0, sreq = 1'b0, pfail = 1'b0;
  logic [10:0] addr = 11'h000, maddr;
  logic [7:0] wdata = 8'h00, rdata, dq_h, dq_d;
  logic ready, rsp, done, busy, sel_n, wr_n, oe_n, dq_oe, line_oe, pull, line, line_lo;
  int errors = 0, total_checks = 0, lows = 0;
  always #50 mclk = ~mclk;
  // Pull-up: low while either side pulls
  assign line = !(line_oe || pull);
  always @(posedge mclk) if (!line) lows <= lows + 1;
  nvsq_host #(.RESTORE_CYC(20), .SHADOW_COPY_CYC(50)) dut_u (.mclk_in(mclk), .arst_n_in(arst_n),
    .req_valid_in(valid), .req_write_in(wr), .req_addr_in(addr), .req_wdata_in(wdata), .store_req_in(sreq),
    .req_ready_out(ready), .rsp_valid_out(rsp), .rsp_rdata_out(rdata), .store_done_out(done), .busy_out(busy),
    .mem_addr_out(maddr), .mem_sel_n_out(sel_n), .mem_wr_n_out(wr_n), .mem_oe_n_out(oe_n), .mem_dq_in(dq_d),
    .mem_dq_out(dq_h), .mem_dq_oe_out(dq_oe), .store_busy_line_in(line), .store_busy_line_out(line_lo),
    .store_busy_line_oe_out(line_oe));
  nvsq_dev_model #(.COPY_CYC(30)) dev_u (.clk_in(mclk), .addr_in(maddr), .sel_n_in(sel_n), .wr_n_in(wr_n),
    .oe_n_in(oe_n), .dq_in(dq_oe ? dq_h : ~dq_h), .line_in(line), .pfail_in(pfail), .dq_out(dq_d), .pull_out(pull));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for ready, response or store done
  task wt(input int what);
    int n;
    n = 0;
    while (!(what == 0 ? ready : what == 1 ? rsp : done) && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (n == 200) begin
      errors++;
      give_verdict;
    end
  endtask
  task acc(input logic w, input logic [10:0] a, input logic [7:0] d);
    valid <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    wt(0);
    @(negedge mclk);
    valid <= 1'b0;
    wt(1);
    @(negedge mclk);
    if (!w) chk(rdata, d);
  endtask
  task st;
    lows = 0;
    sreq <= 1'b1;
    wt(2);
    sreq <= 1'b0;
  endtask
  task t_boot;
    repeat (15) @(negedge mclk);
    chk(ready, 1'b0);
    wt(0);
  endtask
  task t_clean_store;
    st;
    chk(lows, 0);
  endtask
  task t_rw;
    acc(1'b1, 11'h000, 8'h3c);
    acc(1'b1, 11'h7ff, 8'hc3);
    acc(1'b0, 11'h000, 8'h3c);
    acc(1'b0, 11'h7ff, 8'hc3);
  endtask
  task t_store;
    acc(1'b1, 11'h155, 8'ha5);
    st;
    chk(lows > 30, 1'b1);
    chk(line_lo, 1'b0);
    acc(1'b0, 11'h155, 8'ha5);
    st;
    chk(lows, 0);
  endtask
  task t_pfail;
    acc(1'b1, 11'h2aa, 8'h5a);
    pfail <= 1'b1;
    @(negedge mclk);
    pfail <= 1'b0;
    @(negedge mclk);
    chk(ready, 1'b0);
    wt(0);
    st;
    chk(lows, 0);
    acc(1'b0, 11'h2aa, 8'h5a);
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    chk(busy, 1'b1);
    arst_n <= 1'b1;
    t_boot;
    t_clean_store;
    t_rw;
    t_store;
    t_pfail;
    give_verdict;
  end
endmodule // tb
`default_nettype wire
